// ### shared/dkrt_pkg.sv
// package of constants for the dual key reset timer
package dkrt_pkg;
    // ********************************************************
    // clock and timing
    // ********************************************************
    localparam int unsigned CLK_HZ            = 25000000;     // system clock rate
    localparam int unsigned DELAY_SHORT_MS    = 7500;         // selectable short delay, ms
    localparam int unsigned DELAY_LONG_MS     = 11250;        // selectable long delay, ms
    localparam int unsigned FIX_DELAY_MS      = 7500;         // fixed default delay, ms
    localparam int unsigned FIX_RELEASE_US    = 234000;       // fixed default release, us
    // other fixed pairings, kept for build choices
    localparam int unsigned ALT1_DELAY_MS     = 10000;        // pairing one delay
    localparam int unsigned ALT1_RELEASE_US   = 313000;       // pairing one release
    localparam int unsigned ALT2_DELAY_MS     = 10000;        // pairing two delay
    localparam int unsigned ALT2_RELEASE_US   = 78000;        // pairing two release
    localparam int unsigned ALT3_DELAY_MS     = 3000;         // pairing three delay
    localparam int unsigned ALT3_RELEASE_US   = 187500;       // pairing three release
    localparam int unsigned CYC_PER_MS        = CLK_HZ / 1000;     // cycles in a millisecond
    localparam int unsigned CYC_PER_US        = CLK_HZ / 1000000;  // cycles in a microsecond
    localparam int unsigned CNT_W             = 32;           // counter width
    localparam logic        SYNC_RST          = 1'b0;         // inverse of the synchroniser reset level
    localparam logic [3:0]  SEL_SETTLE        = 4'h3;         // strap capture waits for the synchroniser
    // state of the timer
    typedef enum logic [3:0] {
        DKRT_IDLE   = 4'b0001,   // waiting for both keys low
        DKRT_COUNT  = 4'b0010,   // counting the output delay
        DKRT_ASSERT = 4'b0100,   // reset out is low
        DKRT_LOCK   = 4'b1000    // auto released, waiting for a key release
    } dkrt_state_t;
endpackage : dkrt_pkg

// ### rtl/dkrt_sync.sv
// two flop synchroniser for the pin inputs
`timescale 1ns/1ps
module dkrt_sync (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta;   // first stage, read only by the second
    // resets to high so idle keys are not seen as pressed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= ~dkrt_pkg::SYNC_RST;
            o_q  <= ~dkrt_pkg::SYNC_RST;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule : dkrt_sync

// ### rtl/dkrt_timer.sv
// dual key long press reset timer top
//
// Operation
// - count starts when both keys low together
// - key release during count aborts, no reset
// - new press restarts the full delay count
// - selectable variant holds reset while keys low
// - selectable delays are 7.5 s or 11.25 s
// - fixed variant auto releases after release time
// - default fixed 7.5 s delay, 0.234 s release
// - other pairs 10/0.313, 10/0.078, 3/0.1875
`timescale 1ns/1ps
module dkrt_timer #(
    // the other fixed pairings are built by overriding DELAY_MS and RELEASE_US
    parameter bit          FIXED_MODE  = 1'b0,                       // 1 selects the auto release variant
    parameter int unsigned DELAY_MS    = dkrt_pkg::FIX_DELAY_MS,     // fixed variant delay
    parameter int unsigned RELEASE_US  = dkrt_pkg::FIX_RELEASE_US,   // fixed variant release
    parameter int unsigned SHORT_MS    = dkrt_pkg::DELAY_SHORT_MS,   // selectable short delay
    parameter int unsigned LONG_MS     = dkrt_pkg::DELAY_LONG_MS     // selectable long delay
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_key_in_a_n,
    input  wire logic i_key_in_b_n,
    input  wire logic i_delay_sel,
    output logic      o_rst_n,
    output logic      o_rst_oe
);
    // ********************************************************
    // derived cycle counts
    // ********************************************************
    // scales a duration to cycles; multiplied in 64 bits but returned in 32, so very long delays wrap
    function automatic logic [31:0] to_cyc(input int unsigned amount, input int unsigned per_unit);
        return 32'(64'(amount) * 64'(per_unit));
    endfunction : to_cyc
    localparam logic [31:0] CYC_SHORT = to_cyc(SHORT_MS, dkrt_pkg::CYC_PER_MS);
    localparam logic [31:0] CYC_LONG  = to_cyc(LONG_MS, dkrt_pkg::CYC_PER_MS);
    localparam logic [31:0] CYC_FIXED = to_cyc(DELAY_MS, dkrt_pkg::CYC_PER_MS);
    localparam logic [31:0] CYC_REL   = to_cyc(RELEASE_US, dkrt_pkg::CYC_PER_US);

    // ********************************************************
    // input synchronisers
    // ********************************************************
    logic key_a_n;       // synchronised key a
    logic key_b_n;       // synchronised key b
    logic sel_sync;      // synchronised select strap
    dkrt_sync u_sync_a (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_key_in_a_n), .o_q(key_a_n));
    dkrt_sync u_sync_b (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_key_in_b_n), .o_q(key_b_n));
    dkrt_sync u_sync_s (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_delay_sel), .o_q(sel_sync));

    // both keys pressed; a tied low unused key leaves the other in control
    logic both_low;
    assign both_low = ~key_a_n & ~key_b_n;

    // ********************************************************
    // delay strap capture
    // ********************************************************
    logic        sel_taken;  // strap already captured
    logic        sel_long;   // captured strap level
    logic [3:0]  settle;     // waits for the synchroniser to fill
    // captured once after reset; later strap changes are ignored, which is why
    // the board must not move it while powered
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_taken <= 1'b0;
            sel_long  <= 1'b0;
            settle    <= 4'h0;
        end else if (!sel_taken) begin
            settle <= settle + 4'h1;
            if (settle == dkrt_pkg::SEL_SETTLE) begin
                sel_taken <= 1'b1;
                sel_long  <= sel_sync;
            end
        end
    end

    // delay target for this build
    logic [31:0] delay_cyc;
    always_comb begin
        if (FIXED_MODE) begin
            delay_cyc = CYC_FIXED;
        end else if (sel_long) begin
            delay_cyc = CYC_LONG;
        end else begin
            delay_cyc = CYC_SHORT;
        end
    end

    // ********************************************************
    // state machine
    // ********************************************************
    // the lock state is reached only in the fixed build: it stops a held pair of
    // keys from firing a second reset right after the automatic release
    dkrt_pkg::dkrt_state_t state;       // present state
    dkrt_pkg::dkrt_state_t next_state;  // next state
    logic [31:0]           cnt;         // delay or release counter
    logic                  delay_done;  // delay reached
    logic                  rel_done;    // release reached
    // the counter is zero on entry, so the last count is one short of the target
    assign delay_done = (cnt >= delay_cyc - 32'h1);
    assign rel_done   = (cnt >= CYC_REL - 32'h1);

    always_comb begin
        next_state = state;
        case (state)
            dkrt_pkg::DKRT_IDLE: begin
                if (both_low && sel_taken) begin
                    next_state = dkrt_pkg::DKRT_COUNT;
                end
            end
            dkrt_pkg::DKRT_COUNT: begin
                if (!both_low) begin
                    next_state = dkrt_pkg::DKRT_IDLE;
                end else if (delay_done) begin
                    next_state = dkrt_pkg::DKRT_ASSERT;
                end
            end
            dkrt_pkg::DKRT_ASSERT: begin
                if (!both_low) begin
                    next_state = dkrt_pkg::DKRT_IDLE;
                end else if (FIXED_MODE && rel_done) begin
                    next_state = dkrt_pkg::DKRT_LOCK;
                end
            end
            dkrt_pkg::DKRT_LOCK: begin
                if (!both_low) begin
                    next_state = dkrt_pkg::DKRT_IDLE;
                end
            end
            default: next_state = dkrt_pkg::DKRT_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= dkrt_pkg::DKRT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // counter clears on every state change so a new press starts at zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 32'h0;
        end else if (next_state != state) begin
            cnt <= 32'h0;
        end else if (state == dkrt_pkg::DKRT_COUNT || state == dkrt_pkg::DKRT_ASSERT) begin
            cnt <= cnt + 32'h1;
        end
    end

    // output from a flop; open drain style, oe high while pulling low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rst_n <= 1'b1;
        end else begin
            o_rst_n <= (next_state != dkrt_pkg::DKRT_ASSERT);
        end
    end
    assign o_rst_oe = ~o_rst_n;

    // ********************************************************
    // assertions
    // ********************************************************
    // a press that ends before the delay, and a lockout left by a key release
    sequence s_count_then_abort;
        (state == dkrt_pkg::DKRT_COUNT) ##1 (state == dkrt_pkg::DKRT_IDLE);
    endsequence
    sequence s_lock_then_idle;
        (state == dkrt_pkg::DKRT_LOCK) ##1 (state == dkrt_pkg::DKRT_IDLE);
    endsequence

    // a released key must end or prevent the reset
    AST_NO_ASSERT_UNPRESSED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !both_low |=> o_rst_n) else $error("reset asserted with a key released");
    AST_ABORT_NO_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_count_then_abort |-> o_rst_n) else $error("aborted count gave reset");
    // a fresh press starts from zero, and only with both keys down
    AST_RESTART_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == dkrt_pkg::DKRT_IDLE) ##1 (state == dkrt_pkg::DKRT_COUNT) |-> cnt == 32'h0)
        else $error("count did not restart from zero");
    AST_START_ON_BOTH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state == dkrt_pkg::DKRT_COUNT) |-> $past(both_low))
        else $error("count started without both keys low");
    // the reset may only fall at the end of a whole count
    AST_ASSERT_AFTER_DELAY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_rst_n) |-> $past(state) == dkrt_pkg::DKRT_COUNT && $past(delay_done))
        else $error("reset asserted before the full delay");
    AST_DELAY_VALUE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!FIXED_MODE && $fell(o_rst_n)) |-> $past(cnt) == (sel_long ? CYC_LONG : CYC_SHORT) - 32'h1)
        else $error("wrong delay chosen");
    // selectable build keeps the line low while both keys stay down
    AST_HOLD_SELECTABLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!FIXED_MODE && !o_rst_n && both_low) |=> !o_rst_n)
        else $error("selectable reset released while keys low");
    // strap is taken once and nothing counts before it is taken
    AST_SEL_FROZEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sel_taken |=> $stable(sel_long)) else $error("strap changed after capture");
    AST_IDLE_UNTIL_STRAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !sel_taken |=> state == dkrt_pkg::DKRT_IDLE) else $error("count started before strap capture");
    // fixed build holds until the release time, then lets go by itself
    AST_AUTO_RELEASE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (FIXED_MODE && state == dkrt_pkg::DKRT_ASSERT && both_low && rel_done) |=> o_rst_n)
        else $error("fixed reset not released in time");
    AST_FIXED_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (FIXED_MODE && !o_rst_n && both_low && !rel_done) |=> !o_rst_n)
        else $error("fixed reset released before its time");
    // after an automatic release only a key release rearms the timer
    AST_LOCK_NO_RESTART: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == dkrt_pkg::DKRT_LOCK) |=> state != dkrt_pkg::DKRT_COUNT)
        else $error("count restarted without key release");
    AST_LOCK_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == dkrt_pkg::DKRT_LOCK) |-> o_rst_n) else $error("reset low during lockout");
    AST_LOCK_EXIT_ON_KEY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_lock_then_idle |-> !$past(both_low)) else $error("lockout left with both keys low");
endmodule : dkrt_timer

// ### tb/dkrt_keys.sv
// key pair and host reset line model for the reset timer bench
`timescale 1ns/1ps
module dkrt_keys (
    input  wire logic i_press_a,
    input  wire logic i_press_b,
    input  wire logic i_rst_n,
    input  wire logic i_rst_oe,
    output logic      o_key_a_n,
    output logic      o_key_b_n,
    output logic      o_host_rst_n
);
    // ********************************************************
    // keys and host line
    // ********************************************************
    // a closed key grounds its line, an open one is pulled up
    assign o_key_a_n = ~i_press_a;
    // an unused key is simply held pressed by the bench
    assign o_key_b_n = ~i_press_b;
    // open drain line with a pull-up: a released pin reads high, never the last value
    assign o_host_rst_n = i_rst_oe ? i_rst_n : 1'b1;
endmodule : dkrt_keys

// ### tb/test_dkrt_timer.sv
// self-checking bench for the dual key reset timer
`timescale 1ns/1ps
module test_dkrt_timer;
    // ********************************************************
    // signals
    // ********************************************************
    localparam int D = 25000;                   // 1 ms delay in cycles
    localparam int R = 250;                     // 10 us release in cycles
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_delay_sel = 1'b0;
    logic press_a = 1'b0, press_b = 1'b0;       // key closures
    logic ka_n, kb_n, ka2_n, kb2_n;             // key lines
    logic sel_rst_n, sel_oe, fix_rst_n, fix_oe; // timer outputs
    logic sel_host_n, fix_host_n;               // host view of each line
    int   n_errors = 0, n_tests = 0;
    always #20 i_clk = ~i_clk;                  // 25 MHz
    // selectable variant by default, delays shortened to 1 ms and 2 ms
    dkrt_timer #(.SHORT_MS(1), .LONG_MS(2)) dkrt_timer_inst (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_key_in_a_n(ka_n), .i_key_in_b_n(kb_n), .i_delay_sel(i_delay_sel),
        .o_rst_n(sel_rst_n), .o_rst_oe(sel_oe));
    // fixed variant, 1 ms delay, 10 us release
    dkrt_timer #(.FIXED_MODE(1'b1), .DELAY_MS(1), .RELEASE_US(10)) dkrt_timer_fix_inst (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_key_in_a_n(ka2_n), .i_key_in_b_n(kb2_n), .i_delay_sel(i_delay_sel),
        .o_rst_n(fix_rst_n), .o_rst_oe(fix_oe));
    dkrt_keys dkrt_keys_inst (.i_press_a(press_a), .i_press_b(press_b), .i_rst_n(sel_rst_n),
        .i_rst_oe(sel_oe), .o_key_a_n(ka_n), .o_key_b_n(kb_n), .o_host_rst_n(sel_host_n));
    dkrt_keys dkrt_keys_fix_inst (.i_press_a(press_a), .i_press_b(press_b), .i_rst_n(fix_rst_n),
        .i_rst_oe(fix_oe), .o_key_a_n(ka2_n), .o_key_b_n(kb2_n), .o_host_rst_n(fix_host_n));
    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic give_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // compare one line level
    task automatic chk(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : chk
    function automatic logic rst_of(input int w);
        return (w == 0) ? sel_host_n : fix_host_n;
    endfunction : rst_of
    // bounded wait for a level; the cycle count must fall in lo..hi
    task automatic wait_lvl(input int w, input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (rst_of(w) !== lvl && n <= hi) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        n_tests++;
        if (n < lo || n > hi) begin
            n_errors++;
            $display("BAD %0t line %0d took %0d cycles", $time, w, n);
            if (n > hi) give_verdict();
        end
    endtask : wait_lvl
    // strap only changes while held in reset, as at power-up
    task automatic do_reset(input logic sel);
        @(posedge i_clk);
        i_rst_n     <= 1'b0;
        i_delay_sel <= sel;
        repeat (8) @(posedge i_clk);
        chk(sel_oe, 1'b0, "driven in reset");
        chk(fix_oe, 1'b0, "fixed driven in reset");
        i_rst_n <= 1'b1;
        repeat (10) @(posedge i_clk);
    endtask : do_reset
    // ********************************************************
    // scenarios
    // ********************************************************
    // long hold: both fire, fixed releases alone and stays locked out
    task automatic test_hold();
        press_a <= 1'b1;
        press_b <= 1'b1;
        wait_lvl(0, 1'b0, D, D + 6);
        chk(fix_host_n, 1'b0, "fixed not asserted");
        wait_lvl(1, 1'b1, R - 2, R + 3);
        chk(sel_host_n, 1'b0, "held reset dropped");
        repeat (100) @(posedge i_clk);
        chk(fix_host_n, 1'b1, "recount after auto release");
        press_a <= 1'b0;
        wait_lvl(0, 1'b1, 1, 5);
        $display("test_hold done");
    endtask : test_hold
    // abort after 100 cycles, then the full delay again; early key release
    task automatic test_abort();
        @(posedge i_clk);
        press_a <= 1'b1;
        repeat (100) @(posedge i_clk);
        press_b <= 1'b0;
        repeat (20) @(posedge i_clk);
        chk(sel_host_n, 1'b1, "reset after abort");
        press_b <= 1'b1;
        wait_lvl(1, 1'b0, D, D + 6);
        repeat (10) @(posedge i_clk);
        press_b <= 1'b0;
        wait_lvl(1, 1'b1, 1, 5);
        chk(sel_host_n, 1'b1, "held after release");
        $display("test_abort done");
    endtask : test_abort
    // strap high selects the long delay; key b unused and held low
    task automatic test_long();
        press_b <= 1'b1;
        @(posedge i_clk);
        press_a <= 1'b1;
        wait_lvl(0, 1'b0, 2 * D, 2 * D + 6);
        // the fixed copy released long ago; without its lockout it would be low again here
        repeat (R + 10) @(posedge i_clk);
        chk(sel_host_n, 1'b0, "long reset dropped");
        chk(fix_host_n, 1'b1, "fixed recounted while held");
        press_a <= 1'b0;
        wait_lvl(0, 1'b1, 1, 5);
        $display("test_long done");
    endtask : test_long
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        do_reset(1'b0);
        test_hold();
        test_abort();
        do_reset(1'b1);
        test_long();
        give_verdict();
    end
endmodule : test_dkrt_timer
